/* hdl/lrc_pkg.sv */
// Purpose: Constants, register map and types for the line region cropper.
// Assumes: 100 MHz pixel clock; byte addresses on the register port.
// Notes:   Widths are in pixels unless stated otherwise.
//
// Notes on behaviour
// - One to four pixel regions per line are programmable.
// - Pixels outside every enabled region never reach the output.
// - Regions leave as one contiguous line, length equal to summed spans.
// - Region settings change only while capture is stopped.
// - Each region span is at least 96 pixels.
// - Capture starts only if summed span of enabled regions is at least 1,024 pixels.
// - Capture starts only if summed span of enabled regions is at most 16,384 pixels.
// - No output lane carries more than 8k bytes per line.
// - Region spans move in steps of 32 pixels.
// - Region start column lies between 0 and 16,288.
// - Regions may overlap; shared pixels repeat once per region.
// - Changing a start column shrinks the span to stay inside the line.
// - Other regions lower both a region's maximum span and its minimum span.
// - Regions leave in ascending index order from output column zero.
// - Lowering region count pulls the selector to the highest valid index.
// - Illegal start or span values are cut into the legal range; spans round down to a 32-pixel step.
// - After a stop command, capture state reads not capturing.
package lrc_pkg;
  localparam int REGION_MAX  = 4;
  localparam int COL_W       = 15;
  localparam int SUM_W       = 17;
  localparam int PIX_W       = 12;
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 32;
  localparam int LINE_PIXELS = 16384;
  localparam int LANE_COUNT  = 2;
  localparam int LANE_BYTES  = 8192;

  // Region limits
  localparam logic [COL_W-1:0] LINE_LEN   = 15'h4000;
  localparam logic [COL_W-1:0] LINE_LAST  = 15'h3fff;
  localparam logic [COL_W-1:0] SPAN_MIN   = 15'h0060;
  localparam logic [COL_W-1:0] SPAN_MASK  = 15'h7fe0;
  localparam logic [SUM_W-1:0] STEP_ROUND = 17'h0001f;
  localparam logic [COL_W-1:0] START_MAX  = 15'h3fa0;
  localparam logic [SUM_W-1:0] TOTAL_MIN  = 17'h00400;
  localparam logic [SUM_W-1:0] TOTAL_MAX  = 17'h04000;
  localparam logic [SUM_W-1:0] LANE_PIX_NARROW = SUM_W'(LANE_COUNT * LANE_BYTES);
  localparam logic [SUM_W-1:0] LANE_PIX_WIDE   = SUM_W'(LANE_COUNT * LANE_BYTES / 2);

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_COUNT  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SELECT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_START  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_SPAN   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_FORMAT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_TOTAL  = 8'h1c;

  // Field positions
  localparam int CTRL_START_BIT  = 0;
  localparam int CTRL_STOP_BIT   = 1;
  localparam int FORMAT_WIDE_BIT = 0;

  // Reset values
  localparam logic [2:0]       COUNT_RST  = 3'h1;
  localparam logic [COL_W-1:0] START_RST  = 15'h0000;
  localparam logic [COL_W-1:0] SPAN0_RST  = 15'h4000;
  localparam logic [COL_W-1:0] SPANX_RST  = 15'h0060;

  typedef enum logic {LRC_COLLECT, LRC_PLAY} lrc_state_t;
endpackage

/* hdl/lrc_mem_if.sv */
`timescale 1ns/1ns
// Purpose: Write and read port of the sensor line store.
// Assumes: One write and one combinational read per cycle.
// Notes:   Write indices at or above the line length are ignored.
interface lrc_mem_if;
  import lrc_pkg::*;
  logic             wr_en;
  logic [COL_W-1:0] wr_idx;
  logic [PIX_W-1:0] wr_data;
  logic [COL_W-1:0] rd_idx;
  logic [PIX_W-1:0] rd_data;

  modport user  (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport store (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface

/* hdl/lrc_line_mem.sv */
`timescale 1ns/1ns
// Purpose: Holds one full sensor line so regions can be replayed in any order.
// Assumes: Storage has no reset; only written columns are ever read back.
// Notes:   Replay of overlapping regions needs the whole line held.
module lrc_line_mem
  import lrc_pkg::*;
(
  // Clock
  input  logic      CLK,
  // Store port
  lrc_mem_if.store  mem
);
  logic [PIX_W-1:0] line_ff [LINE_PIXELS];

  // Storage write; kept as a direct indexed write to avoid copying the array
  always_ff @(posedge CLK) begin
    if (mem.wr_en && (mem.wr_idx < LINE_LEN)) begin
      line_ff[mem.wr_idx[COL_W-2:0]] <= mem.wr_data;
    end
  end

  always_comb begin
    mem.rd_data = line_ff[mem.rd_idx[COL_W-2:0]];
  end
endmodule // lrc_line_mem

/* hdl/lrc_span_limit.sv */
`timescale 1ns/1ns
// Purpose: Cuts a requested region span into its legal range, rounded down to a 32-pixel step.
// Assumes: Start column already inside its legal range.
// Notes:   Purely combinational.
module lrc_span_limit
  import lrc_pkg::*;
(
  // Request
  input  logic [lrc_pkg::SUM_W-1:0] req_span,
  input  logic [lrc_pkg::COL_W-1:0] start_col,
  // Context from the other enabled regions and the format setting
  input  logic [lrc_pkg::SUM_W-1:0] others_sum,
  input  logic [lrc_pkg::SUM_W-1:0] total_max,
  // Result
  output logic [lrc_pkg::COL_W-1:0] span
);
  logic [SUM_W-1:0] hi;
  logic [SUM_W-1:0] lo;
  logic [SUM_W-1:0] val;

  always_comb begin
    hi = SUM_W'(LINE_LEN - start_col);
    if (total_max <= others_sum) begin
      hi = '0;
    end else if ((total_max - others_sum) < hi) begin
      hi = total_max - others_sum;
    end
    hi = hi & SUM_W'(SPAN_MASK);
    lo = SUM_W'(SPAN_MIN);
    if ((TOTAL_MIN > others_sum) &&
        (((TOTAL_MIN - others_sum + STEP_ROUND) & SUM_W'(SPAN_MASK)) > lo)) begin
      lo = (TOTAL_MIN - others_sum + STEP_ROUND) & SUM_W'(SPAN_MASK);
    end
    val = req_span & SUM_W'(SPAN_MASK);
    if (val < lo) begin
      val = lo;
    end
    if (val > hi) begin
      val = hi;
    end
    if (val < SUM_W'(SPAN_MIN)) begin
      val = SUM_W'(SPAN_MIN);
    end
    span = val[COL_W-1:0];
  end
endmodule // lrc_span_limit

/* hdl/lrc_cropper.sv */
`timescale 1ns/1ns
// Purpose: Crops up to four pixel regions from each sensor line and packs
//          them into one contiguous output line.
// Assumes: Sensor stream is on CLK; a line is 16,384 pixels starting at SOL.
// Notes:   Input is refused while a packed line is being played out.
module lrc_cropper
  import lrc_pkg::*;
(
  // Clock and reset
  input  logic                        CLK,
  input  logic                        NRST,
  // Register port
  input  logic [lrc_pkg::ADDR_W-1:0]  REG_ADDR,
  input  logic [lrc_pkg::DATA_W-1:0]  REG_WDATA,
  input  logic                        REG_WR,
  input  logic                        REG_RD,
  output logic [lrc_pkg::DATA_W-1:0]  REG_RDATA,
  // Sensor pixel stream
  input  logic                        PIX_IN_VALID,
  input  logic                        PIX_IN_SOL,
  input  logic [lrc_pkg::PIX_W-1:0]   PIX_IN_DATA,
  output logic                        PIX_IN_READY,
  // Packed output line
  output logic                        PIX_OUT_VALID,
  output logic                        PIX_OUT_SOL,
  output logic                        PIX_OUT_EOL,
  output logic [lrc_pkg::PIX_W-1:0]   PIX_OUT_DATA,
  // Status
  output logic                        CAPTURE_STATE
);
  import lrc_pkg::*;

  // Configuration state
  logic [2:0]       count_ff;
  logic [2:0]       nxt_count;
  logic [1:0]       sel_ff;
  logic [1:0]       nxt_sel;
  logic [COL_W-1:0] start_ff     [REGION_MAX];
  logic [COL_W-1:0] nxt_start    [REGION_MAX];
  logic [COL_W-1:0] span_ff      [REGION_MAX];
  logic [COL_W-1:0] nxt_span     [REGION_MAX];
  logic [COL_W-1:0] act_start_ff [REGION_MAX];
  logic [COL_W-1:0] nxt_act_start[REGION_MAX];
  logic [COL_W-1:0] act_span_ff  [REGION_MAX];
  logic [COL_W-1:0] nxt_act_span [REGION_MAX];
  logic [2:0]       act_count_ff;
  logic [2:0]       nxt_act_count;
  logic             wide_ff;
  logic             nxt_wide;
  logic             capture_ff;
  logic             nxt_capture;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;

  // Derived configuration values
  logic [SUM_W-1:0] total_sum;
  logic [SUM_W-1:0] others_sum;
  logic [SUM_W-1:0] total_max;
  logic             cfg_ok;
  logic             cfg_wr;
  logic [COL_W-1:0] new_start;
  logic [SUM_W-1:0] req_span;
  logic [COL_W-1:0] span_for_write;
  logic [COL_W-1:0] span_for_start;
  logic [2:0]       cnt_req;
  logic [DATA_W-1:0] rd_value;

  // Datapath state
  lrc_state_t       state_ff;
  lrc_state_t       nxt_state;
  logic [COL_W-1:0] wr_col_ff;
  logic [COL_W-1:0] nxt_wr_col;
  logic [1:0]       reg_idx_ff;
  logic [1:0]       nxt_reg_idx;
  logic [COL_W-1:0] rd_col_ff;
  logic [COL_W-1:0] nxt_rd_col;
  logic [COL_W-1:0] left_ff;
  logic [COL_W-1:0] nxt_left;
  logic             first_ff;
  logic             nxt_first;
  logic             out_valid_ff;
  logic             nxt_out_valid;
  logic             out_sol_ff;
  logic             nxt_out_sol;
  logic             out_eol_ff;
  logic             nxt_out_eol;
  logic [PIX_W-1:0] out_data_ff;
  logic [PIX_W-1:0] nxt_out_data;
  logic [COL_W-1:0] in_col;
  logic             last_region;

  lrc_mem_if mem_bus ();

  lrc_line_mem u_line_mem (
    .CLK (CLK),
    .mem (mem_bus)
  );

  // Span request for the selected region
  lrc_span_limit u_limit_span (
    .req_span   (req_span),
    .start_col  (start_ff[sel_ff]),
    .others_sum (others_sum),
    .total_max  (total_max),
    .span       (span_for_write)
  );

  // Existing span refitted to a new start column
  lrc_span_limit u_limit_start (
    .req_span   (SUM_W'(span_ff[sel_ff])),
    .start_col  (new_start),
    .others_sum (others_sum),
    .total_max  (total_max),
    .span       (span_for_start)
  );

  always_comb begin
    total_sum  = '0;
    others_sum = '0;
    for (int i = 0; i < REGION_MAX; i++) begin
      if (i < int'(count_ff)) begin
        total_sum = total_sum + SUM_W'(span_ff[i]);
        if (i != int'(sel_ff)) begin
          others_sum = others_sum + SUM_W'(span_ff[i]);
        end
      end
    end
    total_max = wide_ff ? LANE_PIX_WIDE : LANE_PIX_NARROW;
    if (total_max > TOTAL_MAX) begin
      total_max = TOTAL_MAX;
    end
    cfg_ok = (total_sum >= TOTAL_MIN) && (total_sum <= total_max);
  end

  always_comb begin
    new_start = (REG_WDATA > DATA_W'(START_MAX)) ? START_MAX : REG_WDATA[COL_W-1:0];
    req_span  = (REG_WDATA > DATA_W'(TOTAL_MAX)) ? TOTAL_MAX : REG_WDATA[SUM_W-1:0];
    if (REG_WDATA == '0) begin
      cnt_req = 3'h1;
    end else if (REG_WDATA > DATA_W'(REGION_MAX)) begin
      cnt_req = 3'(REGION_MAX);
    end else begin
      cnt_req = REG_WDATA[2:0];
    end
  end

  assign cfg_wr = REG_WR && !capture_ff;

  always_comb begin
    nxt_count     = count_ff;
    nxt_sel       = sel_ff;
    nxt_start     = start_ff;
    nxt_span      = span_ff;
    nxt_act_start = act_start_ff;
    nxt_act_span  = act_span_ff;
    nxt_act_count = act_count_ff;
    nxt_wide      = wide_ff;
    nxt_capture   = capture_ff;
    if (cfg_wr) begin
      case (REG_ADDR)
        OFS_COUNT: begin
          nxt_count = cnt_req;
          if (cnt_req < count_ff) begin
            nxt_sel = 2'(cnt_req - 3'h1);
          end
        end
        OFS_SELECT: begin
          if (REG_WDATA >= DATA_W'(count_ff)) begin
            nxt_sel = 2'(count_ff - 3'h1);
          end else begin
            nxt_sel = REG_WDATA[1:0];
          end
        end
        OFS_START: begin
          nxt_start[sel_ff] = new_start;
          nxt_span[sel_ff] = span_for_start;
        end
        OFS_SPAN: begin
          nxt_span[sel_ff] = span_for_write;
        end
        OFS_FORMAT: begin
          nxt_wide = REG_WDATA[FORMAT_WIDE_BIT];
        end
        default: begin
        end
      endcase
    end
    if (REG_WR && (REG_ADDR == OFS_CTRL)) begin
      if (REG_WDATA[CTRL_STOP_BIT]) begin
        nxt_capture = 1'b0;
      end else if (REG_WDATA[CTRL_START_BIT] && !capture_ff && cfg_ok) begin
        nxt_capture = 1'b1;
        nxt_act_start = start_ff;
        nxt_act_span  = span_ff;
        nxt_act_count = count_ff;
      end
    end
  end

  always_comb begin
    case (REG_ADDR)
      OFS_STATUS: rd_value = DATA_W'({(state_ff == LRC_PLAY), cfg_ok, capture_ff});
      OFS_COUNT:  rd_value = DATA_W'(count_ff);
      OFS_SELECT: rd_value = DATA_W'(sel_ff);
      OFS_START:  rd_value = DATA_W'(start_ff[sel_ff]);
      OFS_SPAN:   rd_value = DATA_W'(span_ff[sel_ff]);
      OFS_FORMAT: rd_value = DATA_W'(wide_ff);
      OFS_TOTAL:  rd_value = DATA_W'(total_sum);
      default:    rd_value = '0;
    endcase
    nxt_rdata = REG_RD ? rd_value : '0;
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      count_ff     <= COUNT_RST;
      sel_ff       <= '0;
      act_count_ff <= COUNT_RST;
      wide_ff      <= 1'b0;
      capture_ff   <= 1'b0;
      rdata_ff     <= '0;
      for (int i = 0; i < REGION_MAX; i++) begin
        start_ff[i]     <= START_RST;
        span_ff[i]      <= (i == 0) ? SPAN0_RST : SPANX_RST;
        act_start_ff[i] <= START_RST;
        act_span_ff[i]  <= (i == 0) ? SPAN0_RST : SPANX_RST;
      end
    end else begin
      count_ff     <= nxt_count;
      sel_ff       <= nxt_sel;
      act_count_ff <= nxt_act_count;
      wide_ff      <= nxt_wide;
      capture_ff   <= nxt_capture;
      rdata_ff     <= nxt_rdata;
      start_ff     <= nxt_start;
      span_ff      <= nxt_span;
      act_start_ff <= nxt_act_start;
      act_span_ff  <= nxt_act_span;
    end
  end

  // Line store ports
  assign in_col          = PIX_IN_SOL ? '0 : wr_col_ff;
  assign PIX_IN_READY    = (state_ff == LRC_COLLECT);
  assign mem_bus.wr_en   = PIX_IN_VALID && PIX_IN_READY;
  assign mem_bus.wr_idx  = in_col;
  assign mem_bus.wr_data = PIX_IN_DATA;
  assign mem_bus.rd_idx  = rd_col_ff;
  assign last_region     = ({1'b0, reg_idx_ff} == (act_count_ff - 3'h1));

  always_comb begin
    nxt_state     = state_ff;
    nxt_wr_col    = wr_col_ff;
    nxt_reg_idx   = reg_idx_ff;
    nxt_rd_col    = rd_col_ff;
    nxt_left      = left_ff;
    nxt_first     = first_ff;
    nxt_out_valid = 1'b0;
    nxt_out_sol   = 1'b0;
    nxt_out_eol   = 1'b0;
    nxt_out_data  = out_data_ff;
    case (state_ff)
      LRC_COLLECT: begin
        if (PIX_IN_VALID) begin
          nxt_wr_col = in_col + 15'h0001;
          if (in_col == LINE_LAST) begin
            nxt_wr_col = '0;
            if (capture_ff) begin
              nxt_state   = LRC_PLAY;
              nxt_reg_idx = '0;
              nxt_rd_col  = act_start_ff[0];
              nxt_left    = act_span_ff[0];
              nxt_first   = 1'b1;
            end
          end
        end
      end
      LRC_PLAY: begin
        nxt_out_valid = 1'b1;
        nxt_out_data  = mem_bus.rd_data;
        nxt_out_sol   = first_ff;
        nxt_first     = 1'b0;
        nxt_rd_col    = rd_col_ff + 15'h0001;
        nxt_left      = left_ff - 15'h0001;
        if (left_ff == 15'h0001) begin
          if (last_region) begin
            nxt_out_eol = 1'b1;
            nxt_state   = LRC_COLLECT;
          end else begin
            nxt_reg_idx = reg_idx_ff + 2'h1;
            nxt_rd_col  = act_start_ff[reg_idx_ff + 2'h1];
            nxt_left    = act_span_ff[reg_idx_ff + 2'h1];
          end
        end
      end
      default: begin
        nxt_state = LRC_COLLECT;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_ff     <= LRC_COLLECT;
      wr_col_ff    <= '0;
      reg_idx_ff   <= '0;
      rd_col_ff    <= '0;
      left_ff      <= '0;
      first_ff     <= 1'b0;
      out_valid_ff <= 1'b0;
      out_sol_ff   <= 1'b0;
      out_eol_ff   <= 1'b0;
      out_data_ff  <= '0;
    end else begin
      state_ff     <= nxt_state;
      wr_col_ff    <= nxt_wr_col;
      reg_idx_ff   <= nxt_reg_idx;
      rd_col_ff    <= nxt_rd_col;
      left_ff      <= nxt_left;
      first_ff     <= nxt_first;
      out_valid_ff <= nxt_out_valid;
      out_sol_ff   <= nxt_out_sol;
      out_eol_ff   <= nxt_out_eol;
      out_data_ff  <= nxt_out_data;
    end
  end

  assign REG_RDATA     = rdata_ff;
  assign PIX_OUT_VALID = out_valid_ff;
  assign PIX_OUT_SOL   = out_sol_ff;
  assign PIX_OUT_EOL   = out_eol_ff;
  assign PIX_OUT_DATA  = out_data_ff;
  assign CAPTURE_STATE = capture_ff;
endmodule // lrc_cropper

/* verif/lrc_chk.sv */
`timescale 1ns/1ns
// Purpose: Port assertions for the line region cropper.
// Assumes: One clock domain; NRST asynchronous, active low.
// Notes:   Bound to lrc_cropper below the module.
module lrc_chk
  import lrc_pkg::*;
(
  // Clock and reset
  input wire logic              CLK,
  input wire logic              NRST,
  // Register port
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [DATA_W-1:0] REG_WDATA,
  input wire logic              REG_WR,
  input wire logic              REG_RD,
  input wire logic [DATA_W-1:0] REG_RDATA,
  // Streams and status
  input wire logic              PIX_IN_READY,
  input wire logic              PIX_OUT_VALID,
  input wire logic              PIX_OUT_SOL,
  input wire logic              PIX_OUT_EOL,
  input wire logic              CAPTURE_STATE
);
  logic [SUM_W-1:0] run_ff;
  logic [SUM_W-1:0] nxt_run;
  logic             ctrl_wr;

  assign ctrl_wr = REG_WR && (REG_ADDR == OFS_CTRL);

  // Pixels already sent in the current output line
  always_comb begin
    nxt_run = '0;
    if (PIX_OUT_VALID && !PIX_OUT_EOL) begin
      nxt_run = run_ff + 17'h00001;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      run_ff <= '0;
    end else begin
      run_ff <= nxt_run;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  a_rdata_only_after: assert property (REG_RDATA != '0 |-> $past(REG_RD))
    else $error("read data outside its cycle");
  a_first_is_sol: assert property ($rose(PIX_OUT_VALID) |-> PIX_OUT_SOL)
    else $error("line did not open with start flag");
  a_line_no_gap: assert property (PIX_OUT_VALID && !PIX_OUT_EOL |=> PIX_OUT_VALID)
    else $error("gap inside output line");
  a_eol_release: assert property (PIX_OUT_EOL |=> PIX_IN_READY && !PIX_OUT_VALID)
    else $error("line end not followed by idle and ready");
  a_play_start: assert property ($fell(PIX_IN_READY) |=> PIX_OUT_VALID && PIX_OUT_SOL)
    else $error("output did not start after input stall");
  a_out_stalls_in: assert property (PIX_OUT_VALID && !PIX_OUT_EOL |-> !PIX_IN_READY)
    else $error("input accepted during playout");
  a_line_max: assert property (PIX_OUT_VALID |-> run_ff < TOTAL_MAX)
    else $error("output line longer than the maximum");
  a_line_min: assert property (PIX_OUT_EOL |-> run_ff >= TOTAL_MIN - 17'h00001)
    else $error("output line shorter than the minimum");
  a_stop_state: assert property (ctrl_wr && REG_WDATA[CTRL_STOP_BIT] |=> !CAPTURE_STATE)
    else $error("capture state still set after stop");
  a_idle_quiet: assert property (!CAPTURE_STATE && PIX_IN_READY |=> !PIX_OUT_VALID)
    else $error("output while not capturing");
  a_start_cause: assert property (!CAPTURE_STATE && !ctrl_wr |=> !CAPTURE_STATE)
    else $error("capture began without a start write");

  c_line_start: cover property ($rose(PIX_OUT_VALID));
  c_line_end: cover property (PIX_OUT_EOL);
  c_stop_cmd: cover property (ctrl_wr && REG_WDATA[CTRL_STOP_BIT]);
endmodule // lrc_chk

bind lrc_cropper lrc_chk chk (.CLK, .NRST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
  .REG_RDATA, .PIX_IN_READY, .PIX_OUT_VALID, .PIX_OUT_SOL, .PIX_OUT_EOL, .CAPTURE_STATE);

/* verif/lrc_grabber.sv */
`timescale 1ns/1ns
// Purpose: Receiving end of the packed line stream.
// Assumes: Always ready; one pixel per valid cycle.
// Notes:   Keeps the last complete line and a count of line ends.
module lrc_grabber
  import lrc_pkg::*;
(
  input wire logic             clk,
  input wire logic             nrst,
  input wire logic             valid,
  input wire logic             sol,
  input wire logic             eol,
  input wire logic [PIX_W-1:0] data
);
  logic [PIX_W-1:0] got[$];
  int               lines = 0;

  always @(posedge clk) begin
    if (nrst && valid) begin
      if (sol) begin
        got.delete();
      end
      got.push_back(data);
      if (eol) begin
        lines++;
      end
    end
  end
endmodule // lrc_grabber

/* verif/testbench.sv */
`timescale 1ns/1ns
// Purpose: Self-checking bench for the line region cropper.
// Assumes: Pixel value is its column modulo 4096 (12-bit pixels), so output order is visible.
// Notes:   Three full sensor lines; about 52k cycles.
module testbench;
  import lrc_pkg::*;
  logic CLK, NRST, REG_WR, REG_RD, PIX_IN_VALID, PIX_IN_SOL, PIX_IN_READY;
  logic PIX_OUT_VALID, PIX_OUT_SOL, PIX_OUT_EOL, CAPTURE_STATE;
  logic [ADDR_W-1:0] REG_ADDR;
  logic [DATA_W-1:0] REG_WDATA, REG_RDATA;
  logic [PIX_W-1:0]  PIX_IN_DATA, PIX_OUT_DATA;
  int                mismatches, num_checks;

  lrc_cropper uut (.CLK, .NRST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
    .PIX_IN_VALID, .PIX_IN_SOL, .PIX_IN_DATA, .PIX_IN_READY, .PIX_OUT_VALID,
    .PIX_OUT_SOL, .PIX_OUT_EOL, .PIX_OUT_DATA, .CAPTURE_STATE);
  lrc_grabber fg (.clk(CLK), .nrst(NRST), .valid(PIX_OUT_VALID), .sol(PIX_OUT_SOL),
    .eol(PIX_OUT_EOL), .data(PIX_OUT_DATA));

  always #5 CLK = ~CLK;

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic timeout(string n);
    mismatches++;
    $display("Error %s expected done seen timeout", n);
    end_sim();
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, string n, logic [31:0] e);
    @(posedge CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1;
    chk(n, e, REG_RDATA);
  endtask

  // Holds each pixel until an edge with ready high takes it
  task automatic send_line();
    int   n;
    logic ok;
    @(posedge CLK);
    for (int c = 0; c < LINE_PIXELS; c++) begin
      PIX_IN_VALID <= 1'b1;
      PIX_IN_SOL <= (c == 0);
      PIX_IN_DATA <= PIX_W'(c);
      n = 0;
      do begin
        @(negedge CLK);
        ok = PIX_IN_READY;
        @(posedge CLK);
        n++;
      end while (!ok && n < 40000);
      if (!ok) timeout("input ready");
    end
    PIX_IN_VALID <= 1'b0;
    PIX_IN_SOL <= 1'b0;
  endtask

  task automatic wait_out(int want);
    int n;
    n = 0;
    while (fg.lines < want && n < 20000) begin
      @(posedge CLK);
      #1;
      n++;
    end
    if (fg.lines < want) timeout("output line");
  endtask

  task automatic cmp_line();
    logic [PIX_W-1:0] e[$];
    for (int c = 8; c < 1032; c++) e.push_back(PIX_W'(c));
    for (int c = 1000; c < 1096; c++) e.push_back(PIX_W'(c));
    chk("line length", e.size(), fg.got.size());
    foreach (e[i]) chk("output pixel", e[i], fg.got[i]);
  endtask

  task automatic t_reset();
    rd(OFS_COUNT, "count", 32'h1);
    rd(OFS_SELECT, "select", 32'h0);
    rd(OFS_START, "start", 32'h0);
    rd(OFS_SPAN, "span", 32'h4000);
    rd(OFS_TOTAL, "total", 32'h4000);
    rd(OFS_STATUS, "status", 32'h2);
    rd(OFS_FORMAT, "format", 32'h0);
    wr(8'h40, 32'hffff);
    rd(8'h40, "unmapped", 32'h0);
    chk("capture state", 32'h0, {31'h0, CAPTURE_STATE});
    $display("test reset done");
  endtask

  task automatic t_span();
    wr(OFS_SPAN, 32'h64);
    rd(OFS_SPAN, "span min total", 32'h400);
    wr(OFS_SPAN, 32'hf9f);
    rd(OFS_SPAN, "span step", 32'hf80);
    wr(OFS_SPAN, 32'h4000);
    wr(OFS_START, 32'h1000);
    rd(OFS_SPAN, "span refit", 32'h3000);
    wr(OFS_START, 32'h7fff);
    rd(OFS_START, "start max", 32'h3fa0);
    rd(OFS_SPAN, "span floor", 32'h60);
    rd(OFS_STATUS, "status low total", 32'h0);
    wr(OFS_START, 32'h0);
    wr(OFS_FORMAT, 32'h1);
    wr(OFS_SPAN, 32'h4000);
    rd(OFS_SPAN, "span wide lanes", 32'h2000);
    wr(OFS_FORMAT, 32'h0);
    wr(OFS_SPAN, 32'h4000);
    rd(OFS_SPAN, "span narrow", 32'h4000);
    $display("test span done");
  endtask

  task automatic t_count();
    wr(OFS_COUNT, 32'h0);
    rd(OFS_COUNT, "count low", 32'h1);
    wr(OFS_COUNT, 32'h7);
    rd(OFS_COUNT, "count high", 32'h4);
    wr(OFS_SELECT, 32'h9);
    rd(OFS_SELECT, "select clamp", 32'h3);
    wr(OFS_SELECT, 32'h0);
    wr(OFS_COUNT, 32'h2);
    rd(OFS_SELECT, "select follow", 32'h1);
    rd(OFS_STATUS, "status over total", 32'h0);
    wr(OFS_CTRL, 32'h1);
    rd(OFS_STATUS, "start refused", 32'h0);
    wr(OFS_SPAN, 32'h4000);
    rd(OFS_SPAN, "span others limit", 32'h60);
    $display("test count done");
  endtask

  task automatic t_capture();
    wr(OFS_SELECT, 32'h0);
    wr(OFS_START, 32'h8);
    wr(OFS_SPAN, 32'h400);
    wr(OFS_SELECT, 32'h1);
    wr(OFS_START, 32'h3e8);
    wr(OFS_SPAN, 32'h60);
    rd(OFS_TOTAL, "total", 32'h460);
    wr(OFS_CTRL, 32'h1);
    rd(OFS_STATUS, "capturing", 32'h3);
    send_line();
    rd(OFS_STATUS, "playing", 32'h7);
    wait_out(1);
    cmp_line();
    wr(OFS_SPAN, 32'h200);
    wr(OFS_COUNT, 32'h1);
    rd(OFS_SPAN, "span frozen", 32'h60);
    rd(OFS_COUNT, "count frozen", 32'h2);
    send_line();
    wait_out(2);
    cmp_line();
    wr(OFS_CTRL, 32'h2);
    #1;
    chk("capture state", 32'h0, {31'h0, CAPTURE_STATE});
    send_line();
    repeat (20) @(posedge CLK);
    #1;
    chk("lines out", 32'h2, fg.lines);
    $display("test capture done");
  endtask

  initial begin
    CLK = 1'b0;
    NRST = 1'b0;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = '0;
    REG_WDATA = '0;
    PIX_IN_VALID = 1'b0;
    PIX_IN_SOL = 1'b0;
    PIX_IN_DATA = '0;
    mismatches = 0;
    num_checks = 0;
    repeat (12) @(posedge CLK);
    NRST <= 1'b1;
    t_reset();
    t_span();
    t_count();
    t_capture();
    end_sim();
  end
endmodule // testbench
